/* hdl/dtlm_defines.vh */
// Purpose: shared constants of the dual temperature limit monitor
// Assumes: 125 MHz core clock
// Notes:   register pointers are byte-wide serial-bus command codes
`ifndef DTLM_DEFINES_VH
`define DTLM_DEFINES_VH

`define DTLM_CLK_KHZ            125000
`define DTLM_CLK_MHZ            125
// conversion time kept in whole microseconds to stay integer
`define DTLM_CONV_TIME_US       31250
`define DTLM_TIMEOUT_MIN_MS     25
`define DTLM_TIMEOUT_MAX_MS     35

`define DTLM_REG_LOCAL_READING  8'h00
`define DTLM_REG_REMOTE_HI      8'h01
`define DTLM_REG_STATUS         8'h02
`define DTLM_REG_CONFIG         8'h03
`define DTLM_REG_RATE           8'h04
`define DTLM_REG_LOCAL_UPPER    8'h05
`define DTLM_REG_LOCAL_LOWER    8'h06
`define DTLM_REG_REM_UPPER_HI   8'h07
`define DTLM_REG_REM_LOWER_HI   8'h08
`define DTLM_REG_REMOTE_LO      8'h10
`define DTLM_REG_OFFSET_HI      8'h11
`define DTLM_REG_OFFSET_LO      8'h12
`define DTLM_REG_REM_UPPER_LO   8'h13
`define DTLM_REG_REM_LOWER_LO   8'h14
`define DTLM_REG_REM_CRIT       8'h19
`define DTLM_REG_LOCAL_CRIT     8'h20
`define DTLM_REG_HYSTERESIS     8'h21

`define DTLM_RST_UPPER          8'h46
`define DTLM_RST_LOWER          8'h00
`define DTLM_RST_CRIT           8'h55
`define DTLM_RST_HYST           8'h0a
`define DTLM_RST_RATE           8'h00
`define DTLM_RST_CONFIG         8'h00

`define DTLM_CFG_MASK_BIT       7
`define DTLM_CFG_STOP_BIT       6

`define DTLM_ST_LHIGH           6
`define DTLM_ST_LLOW            5
`define DTLM_ST_RHIGH           4
`define DTLM_ST_RLOW            3
`define DTLM_ST_RCRIT           1
`define DTLM_ST_LCRIT           0

`endif

/* hdl/dtlm_limit_cmp.v */
// Purpose: limit comparator with critical hysteresis for one reading
// Assumes: signed two's complement reading and limits of equal width
// Notes:   overtemp state only moves on i_update
`timescale 1ns/1ps
`default_nettype none
module dtlm_limit_cmp #(
  parameter integer W = 8
) (
  input  wire         i_core_clk,
  input  wire         i_rstn,
  input  wire         i_update,
  input  wire [W-1:0] i_reading,
  input  wire [W-1:0] i_upper,
  input  wire [W-1:0] i_lower,
  input  wire [W-1:0] i_crit,
  input  wire [W-1:0] i_hyst,
  output wire         o_high,
  output wire         o_low,
  output wire         o_crit,
  output reg          o_overtemp
);
  // two guard bits so crit minus hysteresis cannot wrap
  wire signed [W+1:0] rd_x    = {{2{i_reading[W-1]}}, i_reading};
  wire signed [W+1:0] crit_x  = {{2{i_crit[W-1]}}, i_crit};
  wire signed [W+1:0] rel_lvl = crit_x - $signed({2'b00, i_hyst});

  assign o_high = $signed(i_reading) > $signed(i_upper);
  assign o_low  = $signed(i_reading) < $signed(i_lower);
  assign o_crit = $signed(i_reading) > $signed(i_crit);

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_overtemp <= 1'b0;
    end else if (i_update) begin
      if (o_crit) begin
        o_overtemp <= 1'b1;
      end else if (rd_x < rel_lvl) begin
        o_overtemp <= 1'b0;
      end
    end
  end
endmodule // dtlm_limit_cmp
`default_nettype wire

/* hdl/dtlm_monitor.v */
// Purpose: digital core of a local and remote temperature limit monitor
// Assumes: converter results arrive on the core clock, bus pins are synced
// Notes:   serial slave, conversion sequencer, limits and status
//
// Overview of operation
// - Bus line low beyond timeout resets serial logic and releases lines.
// - Local and remote readings compare against their own three limits.
// - Alert drives when any reading is above high/critical or below low.
// - Overtemp output asserts when a reading rises above its critical limit.
// - Overtemp holds until reading drops below critical minus hysteresis.
// - One hysteresis value serves local and remote critical comparisons.
// - Stop bit enters shutdown; serial interface keeps working.
// - Local reading and local limits are eight-bit registers.
// - Remote reading and high/low limits are 11 bits left-justified in two bytes; remote critical is one byte.
// - Remote reading is corrected by adding the two-byte signed offset.
// - A full local plus remote conversion takes about 31.25 ms.
// - Local and remote conversions repeat in round-robin order.
// - Status bit 7 is high only while a conversion runs.
// - Rate register inserts idle delay; conversion length is unchanged.
// - End of each reading sets status bits for any limit exceeded.
// - Config mask bit 7 disables the alert output.
// - Power-up limits: high +70, low 0, critical +85 degrees.
`timescale 1ns/1ps
`default_nettype none
`include "dtlm_defines.vh"
module dtlm_monitor #(
  parameter [6:0]   P_SLAVE_ADDR     = 7'h2a, // arbitrary
  parameter integer P_CONV_CYCLES    = `DTLM_CONV_TIME_US * `DTLM_CLK_MHZ,
  parameter integer P_TIMEOUT_CYCLES = `DTLM_TIMEOUT_MIN_MS * `DTLM_CLK_KHZ
) (
  input  wire        i_core_clk,
  input  wire        i_rstn,
  input  wire        i_scl,
  output wire        o_scl,
  output wire        o_scl_oe,
  input  wire        i_sda,
  output wire        o_sda,
  output wire        o_sda_oe,
  input  wire [7:0]  i_local_sample,
  input  wire [10:0] i_remote_sample,
  output reg         o_sensor_enable,
  output reg         o_sensor_remote,
  output wire        o_alert_n,
  output reg         o_alert_n_oe,
  output wire        o_overtemp_output_n,
  output reg         o_overtemp_output_n_oe
);
  localparam integer P_HALF = P_CONV_CYCLES / 2;
  localparam integer P_REST = P_CONV_CYCLES - P_HALF;

  localparam [4:0] SB_IDLE = 5'b00001;
  localparam [4:0] SB_RX   = 5'b00010;
  localparam [4:0] SB_ACK  = 5'b00100;
  localparam [4:0] SB_TX   = 5'b01000;
  localparam [4:0] SB_RACK = 5'b10000;

  localparam [3:0] CV_STOP   = 4'b0001;
  localparam [3:0] CV_LOCAL  = 4'b0010;
  localparam [3:0] CV_REMOTE = 4'b0100;
  localparam [3:0] CV_IDLE   = 4'b1000;

  reg [7:0]  local_reading;
  reg [10:0] remote_reading;
  reg [6:0]  status_flags;
  reg [7:0]  device_config;
  reg [7:0]  conversion_rate_select;
  reg [7:0]  local_upper_limit;
  reg [7:0]  local_lower_limit;
  reg [7:0]  local_critical_limit;
  reg [7:0]  remote_upper_limit_hi;
  reg [7:0]  remote_upper_limit_lo;
  reg [7:0]  remote_lower_limit_hi;
  reg [7:0]  remote_lower_limit_lo;
  reg [7:0]  remote_critical_limit;
  reg [7:0]  critical_hysteresis;
  reg [7:0]  remote_offset_high_byte;
  reg [7:0]  remote_offset_low_byte;

  // serial pin synchronisers and edge detection
  reg        scl_meta;
  reg        scl_s;
  reg        scl_d;
  reg        sda_meta;
  reg        sda_s;
  reg        sda_d;
  reg [31:0] to_cnt;
  reg [4:0]  sb_state;
  reg [3:0]  bit_cnt;
  reg [1:0]  byte_idx;
  reg [7:0]  shreg;
  reg [7:0]  txsh;
  reg [7:0]  ptr;
  reg        rw_read;
  reg        master_ack;
  reg [7:0]  rd_data;

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_meta <= 1'b1;
      scl_s    <= 1'b1;
      scl_d    <= 1'b1;
      sda_meta <= 1'b1;
      sda_s    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_meta <= i_scl;
      scl_s    <= scl_meta;
      scl_d    <= scl_s;
      sda_meta <= i_sda;
      sda_s    <= sda_meta;
      sda_d    <= sda_s;
    end
  end

  wire scl_rise  = scl_s & ~scl_d;
  wire scl_fall  = ~scl_s & scl_d;
  wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
  wire bus_stop  = scl_s & scl_d & ~sda_d & sda_s;
  wire bus_timeout = (to_cnt == P_TIMEOUT_CYCLES);

  // saturating count of time either line is low
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      to_cnt <= 32'h0;
    end else if (scl_s & sda_s) begin
      to_cnt <= 32'h0;
    end else if (!bus_timeout) begin
      to_cnt <= to_cnt + 32'h1;
    end
  end

  wire byte_done = (sb_state == SB_RX) & scl_fall & (bit_cnt == 4'h8);
  wire addr_hit  = (shreg[7:1] == P_SLAVE_ADDR);
  wire wr_en     = byte_done & (byte_idx == 2'd2);
  wire tx_load   = scl_fall & (((sb_state == SB_ACK) & rw_read) |
                               ((sb_state == SB_RACK) & master_ack));
  wire rd_clr    = tx_load & (ptr == `DTLM_REG_STATUS);

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sb_state   <= SB_IDLE;
      bit_cnt    <= 4'h0;
      byte_idx   <= 2'd0;
      shreg      <= 8'h00;
      txsh       <= 8'hff;
      ptr        <= 8'h00;
      rw_read    <= 1'b0;
      master_ack <= 1'b0;
    end else if (bus_timeout | bus_stop) begin
      sb_state <= SB_IDLE;
    end else if (bus_start) begin
      sb_state <= SB_RX;
      bit_cnt  <= 4'h0;
      byte_idx <= 2'd0;
      rw_read  <= 1'b0;
    end else begin
      case (sb_state)
        SB_IDLE: begin
          bit_cnt <= 4'h0;
        end
        SB_RX: begin
          if (scl_rise) begin
            shreg   <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_done) begin
            if (byte_idx == 2'd0) begin
              rw_read  <= shreg[0];
              sb_state <= addr_hit ? SB_ACK : SB_IDLE;
            end else begin
              sb_state <= SB_ACK;
              if (byte_idx == 2'd1) begin
                ptr <= shreg;
              end
            end
          end
        end
        SB_ACK: begin
          if (scl_fall) begin
            bit_cnt <= 4'h0;
            if (rw_read) begin
              txsh     <= rd_data;
              sb_state <= SB_TX;
            end else begin
              sb_state <= SB_RX;
              if (byte_idx != 2'd2) begin
                byte_idx <= byte_idx + 2'd1;
              end
            end
          end
        end
        SB_TX: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              sb_state <= SB_RACK;
            end else begin
              txsh <= {txsh[6:0], 1'b1};
            end
          end
        end
        SB_RACK: begin
          if (scl_rise) begin
            master_ack <= ~sda_s;
          end else if (scl_fall) begin
            bit_cnt  <= 4'h0;
            txsh     <= rd_data;
            sb_state <= master_ack ? SB_TX : SB_IDLE;
          end
        end
        default: begin
          sb_state <= SB_IDLE;
        end
      endcase
    end
  end

  // clock stretching is never used, so the clock pin stays released
  assign o_scl    = 1'b0;
  assign o_scl_oe = 1'b0;
  assign o_sda    = 1'b0;
  assign o_sda_oe = (sb_state == SB_ACK) |
                    ((sb_state == SB_TX) & ~txsh[7]);

  // conversion sequencer
  reg [3:0]  cv_state;
  reg [31:0] cv_cnt;
  reg [7:0]  idle_left;
  wire run   = ~device_config[`DTLM_CFG_STOP_BIT];
  wire busy  = (cv_state == CV_LOCAL) | (cv_state == CV_REMOTE);
  wire upd_l = run & (cv_state == CV_LOCAL) & (cv_cnt == P_HALF - 1);
  wire upd_r = run & (cv_state == CV_REMOTE) & (cv_cnt == P_REST - 1);

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cv_state  <= CV_STOP;
      cv_cnt    <= 32'h0;
      idle_left <= 8'h00;
    end else if (!run) begin
      cv_state <= CV_STOP;
      cv_cnt   <= 32'h0;
    end else begin
      case (cv_state)
        CV_STOP: begin
          cv_state <= CV_LOCAL;
        end
        CV_LOCAL: begin
          if (upd_l) begin
            cv_cnt   <= 32'h0;
            cv_state <= CV_REMOTE;
          end else begin
            cv_cnt <= cv_cnt + 32'h1;
          end
        end
        CV_REMOTE: begin
          if (upd_r) begin
            cv_cnt    <= 32'h0;
            idle_left <= conversion_rate_select;
            cv_state  <= (conversion_rate_select == 8'h00) ?
                         CV_LOCAL : CV_IDLE;
          end else begin
            cv_cnt <= cv_cnt + 32'h1;
          end
        end
        CV_IDLE: begin
          if (cv_cnt == P_CONV_CYCLES - 1) begin
            cv_cnt <= 32'h0;
            if (idle_left == 8'h01) begin
              cv_state <= CV_LOCAL;
            end else begin
              idle_left <= idle_left - 8'h01;
            end
          end else begin
            cv_cnt <= cv_cnt + 32'h1;
          end
        end
        default: begin
          cv_state <= CV_STOP;
        end
      endcase
    end
  end

  wire [10:0] remote_offset = {remote_offset_high_byte,
                               remote_offset_low_byte[7:5]};
  wire [10:0] remote_corrected = i_remote_sample + remote_offset;

  wire l_high, l_low, l_crit, l_ot;
  wire r_high, r_low, r_crit, r_ot;

  dtlm_limit_cmp #(.W(8)) u_local_cmp (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_update   (upd_l),
    .i_reading  (i_local_sample),
    .i_upper    (local_upper_limit),
    .i_lower    (local_lower_limit),
    .i_crit     (local_critical_limit),
    .i_hyst     (critical_hysteresis),
    .o_high     (l_high),
    .o_low      (l_low),
    .o_crit     (l_crit),
    .o_overtemp (l_ot)
  );

  dtlm_limit_cmp #(.W(11)) u_remote_cmp (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_update   (upd_r),
    .i_reading  (remote_corrected),
    .i_upper    ({remote_upper_limit_hi, remote_upper_limit_lo[7:5]}),
    .i_lower    ({remote_lower_limit_hi, remote_lower_limit_lo[7:5]}),
    .i_crit     ({remote_critical_limit, 3'h0}),
    .i_hyst     ({critical_hysteresis, 3'h0}),
    .o_high     (r_high),
    .o_low      (r_low),
    .o_crit     (r_crit),
    .o_overtemp (r_ot)
  );

  wire [6:0] st_set = ({l_high, l_low, 4'h0, l_crit} & {7{upd_l}}) |
                      ({2'b00, r_high, r_low, 1'b0, r_crit, 1'b0} &
                       {7{upd_r}});

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      local_reading          <= 8'h00;
      remote_reading         <= 11'h000;
      status_flags           <= 7'h00;
      o_sensor_enable        <= 1'b0;
      o_sensor_remote        <= 1'b0;
      o_alert_n_oe           <= 1'b0;
      o_overtemp_output_n_oe <= 1'b0;
    end else begin
      if (upd_l) begin
        local_reading <= i_local_sample;
      end
      if (upd_r) begin
        remote_reading <= remote_corrected;
      end
      // a new event outranks the clear of a status read
      status_flags <= (status_flags & ~{7{rd_clr}}) | st_set;
      o_sensor_enable <= run;
      o_sensor_remote <= (cv_state == CV_REMOTE);
      o_alert_n_oe <= ~device_config[`DTLM_CFG_MASK_BIT] &
                      (|status_flags);
      o_overtemp_output_n_oe <= l_ot | r_ot;
    end
  end

  assign o_alert_n           = 1'b0;
  assign o_overtemp_output_n = 1'b0;

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      device_config           <= `DTLM_RST_CONFIG;
      conversion_rate_select  <= `DTLM_RST_RATE;
      local_upper_limit       <= `DTLM_RST_UPPER;
      local_lower_limit       <= `DTLM_RST_LOWER;
      local_critical_limit    <= `DTLM_RST_CRIT;
      remote_upper_limit_hi   <= `DTLM_RST_UPPER;
      remote_upper_limit_lo   <= 8'h00;
      remote_lower_limit_hi   <= `DTLM_RST_LOWER;
      remote_lower_limit_lo   <= 8'h00;
      remote_critical_limit   <= `DTLM_RST_CRIT;
      critical_hysteresis     <= `DTLM_RST_HYST;
      remote_offset_high_byte <= 8'h00;
      remote_offset_low_byte  <= 8'h00;
    end else if (wr_en) begin
      case (ptr)
        `DTLM_REG_CONFIG:       device_config           <= shreg;
        `DTLM_REG_RATE:         conversion_rate_select  <= shreg;
        `DTLM_REG_LOCAL_UPPER:  local_upper_limit       <= shreg;
        `DTLM_REG_LOCAL_LOWER:  local_lower_limit       <= shreg;
        `DTLM_REG_LOCAL_CRIT:   local_critical_limit    <= shreg;
        `DTLM_REG_REM_UPPER_HI: remote_upper_limit_hi   <= shreg;
        `DTLM_REG_REM_UPPER_LO: remote_upper_limit_lo   <= shreg & 8'he0;
        `DTLM_REG_REM_LOWER_HI: remote_lower_limit_hi   <= shreg;
        `DTLM_REG_REM_LOWER_LO: remote_lower_limit_lo   <= shreg & 8'he0;
        `DTLM_REG_REM_CRIT:     remote_critical_limit   <= shreg;
        `DTLM_REG_HYSTERESIS:   critical_hysteresis     <= shreg;
        `DTLM_REG_OFFSET_HI:    remote_offset_high_byte <= shreg;
        `DTLM_REG_OFFSET_LO:    remote_offset_low_byte  <= shreg & 8'he0;
        default:                device_config           <= device_config;
      endcase
    end
  end

  always @* begin
    case (ptr)
      `DTLM_REG_LOCAL_READING: rd_data = local_reading;
      `DTLM_REG_REMOTE_HI:     rd_data = remote_reading[10:3];
      `DTLM_REG_REMOTE_LO:     rd_data = {remote_reading[2:0], 5'h00};
      `DTLM_REG_STATUS:        rd_data = {busy, status_flags};
      `DTLM_REG_CONFIG:        rd_data = device_config;
      `DTLM_REG_RATE:          rd_data = conversion_rate_select;
      `DTLM_REG_LOCAL_UPPER:   rd_data = local_upper_limit;
      `DTLM_REG_LOCAL_LOWER:   rd_data = local_lower_limit;
      `DTLM_REG_LOCAL_CRIT:    rd_data = local_critical_limit;
      `DTLM_REG_REM_UPPER_HI:  rd_data = remote_upper_limit_hi;
      `DTLM_REG_REM_UPPER_LO:  rd_data = remote_upper_limit_lo;
      `DTLM_REG_REM_LOWER_HI:  rd_data = remote_lower_limit_hi;
      `DTLM_REG_REM_LOWER_LO:  rd_data = remote_lower_limit_lo;
      `DTLM_REG_REM_CRIT:      rd_data = remote_critical_limit;
      `DTLM_REG_HYSTERESIS:    rd_data = critical_hysteresis;
      `DTLM_REG_OFFSET_HI:     rd_data = remote_offset_high_byte;
      `DTLM_REG_OFFSET_LO:     rd_data = remote_offset_low_byte;
      default:                 rd_data = 8'h00;
    endcase
  end
endmodule // dtlm_monitor
`default_nettype wire

/* bench/dtlm_monitor_checker.sv */
// Purpose: pin-level checks of the limit monitor
// Assumes: bus inputs carry the wired line levels
// Notes: counters other than hi_run saturate, so long holds cost little
`timescale 1ns/1ps
`default_nettype none
module dtlm_monitor_checker #(
  parameter integer P_CONV_CYCLES    = 200,
  parameter integer P_TIMEOUT_CYCLES = 3000
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_scl,
  input wire logic o_scl_oe,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic o_sensor_enable,
  input wire logic o_sensor_remote,
  input wire logic o_overtemp_output_n_oe
);
  localparam integer HALF = P_CONV_CYCLES / 2;
  integer low_scl;
  integer hi_run;
  integer lo_run;
  integer age;
  logic   rem_q;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      low_scl <= 0;
      hi_run  <= 0;
      lo_run  <= 0;
      age     <= 0;
      rem_q   <= 1'b0;
    end else begin
      low_scl <= i_scl ? 0 : low_scl + (low_scl < 2 * P_TIMEOUT_CYCLES);
      hi_run  <= o_sensor_remote ? hi_run + 1 : 0;
      lo_run  <= o_sensor_remote ? 0 : lo_run + (lo_run < 9999);
      age     <= (o_sensor_remote != rem_q) ? 0 : age + (age < 99);
      rem_q   <= o_sensor_remote;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  property p_timeout_release;
    low_scl > P_TIMEOUT_CYCLES + 6 |-> !o_sda_oe;
  endproperty
  a_timeout_release: assert property (p_timeout_release)
    else $error("data line held after clock timeout");
  property p_open_drain;
    !o_scl_oe && !o_sda;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("bus line driven other than low");
  property p_ack_in_low;
    $rose(o_sda_oe) |-> !i_scl;
  endproperty
  a_ack_in_low: assert property (p_ack_in_low)
    else $error("data pull-down began while clock high");
  property p_remote_len;
    $fell(o_sensor_remote) && o_sensor_enable && $past(o_sensor_enable)
      |-> hi_run == P_CONV_CYCLES - HALF;
  endproperty
  a_remote_len: assert property (p_remote_len)
    else $error("remote phase length wrong");
  property p_local_gap;
    $rose(o_sensor_remote) |-> lo_run >= HALF;
  endproperty
  a_local_gap: assert property (p_local_gap)
    else $error("remote phase not preceded by a local phase");
  property p_shutdown_quiet;
    !o_sensor_enable && !$past(o_sensor_enable) |-> !o_sensor_remote;
  endproperty
  a_shutdown_quiet: assert property (p_shutdown_quiet)
    else $error("conversion runs in shutdown");
  property p_overtemp_at_update;
    $changed(o_overtemp_output_n_oe)
      |-> (age <= 4) or (##[0:4] (o_sensor_remote != rem_q));
  endproperty
  a_overtemp_at_update: assert property (p_overtemp_at_update)
    else $error("overtemp moved away from a reading update");
  property p_overtemp_needs_run;
    $changed(o_overtemp_output_n_oe) |-> $past(o_sensor_enable);
  endproperty
  a_overtemp_needs_run: assert property (p_overtemp_needs_run)
    else $error("overtemp moved in shutdown");
endmodule // dtlm_monitor_checker
`default_nettype wire

/* bench/dtlm_host_model.sv */
// Purpose: serial bus host on the far side of the monitor
// Assumes: open-drain lines with pull-ups, 80 ns bit time
// Notes: samples late in the high phase, after device data settles
`timescale 1ns/1ps
`default_nettype none
module dtlm_host_model #(
  parameter [6:0] P_ADDR = 7'h2a
) (
  output logic      o_scl,
  output logic      o_sda,
  input  wire logic i_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic bit_io(input logic b, output logic r);
    #8 o_sda = b;
    #32 o_scl = 1'b1;
    #36 r = i_sda;
    #4 o_scl = 1'b0;
  endtask
  task automatic start();
    o_sda = 1'b1;
    #40 o_scl = 1'b1;
    #40 o_sda = 1'b0;
    #40 o_scl = 1'b0;
  endtask
  task automatic stop();
    #8 o_sda = 1'b0;
    #32 o_scl = 1'b1;
    #40 o_sda = 1'b1;
    #40;
  endtask
  // stall leaves the clock low in the acknowledge slot
  task automatic tx_byte(input logic [7:0] d, input logic stall,
                         output logic ack);
    logic r;
    ack = 1'b0;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    if (!stall) begin
      bit_io(1'b1, r);
      ack = !r;
    end
  endtask
  task automatic write_reg(input logic [7:0] p, input logic [7:0] d,
                           output logic ok);
    logic a0, a1, a2;
    start();
    tx_byte({P_ADDR, 1'b0}, 1'b0, a0);
    tx_byte(p, 1'b0, a1);
    tx_byte(d, 1'b0, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  task automatic read_reg(input logic [7:0] p, output logic [7:0] d,
                          output logic ok);
    logic a0, a1, a2, r;
    start();
    tx_byte({P_ADDR, 1'b0}, 1'b0, a0);
    tx_byte(p, 1'b0, a1);
    start();
    tx_byte({P_ADDR, 1'b1}, 1'b0, a2);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, r);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule // dtlm_host_model
`default_nettype wire

/* bench/testbench.sv */
// Purpose: self-checking bench of the temperature limit monitor
// Assumes: shortened conversion and timeout counts
// Notes: bus lines are the wired-and of host and device
`timescale 1ns/1ps
`default_nettype none
bind dtlm_monitor dtlm_monitor_checker #(
  .P_CONV_CYCLES(P_CONV_CYCLES), .P_TIMEOUT_CYCLES(P_TIMEOUT_CYCLES)
) u_dtlm_monitor_checker (
  .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_scl(i_scl),
  .o_scl_oe(o_scl_oe), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
  .o_sensor_enable(o_sensor_enable), .o_sensor_remote(o_sensor_remote),
  .o_overtemp_output_n_oe(o_overtemp_output_n_oe)
);
module testbench;
  localparam integer CONV = 200;
  localparam integer TMO  = 3000;
  localparam [6:0]   ADDR = 7'h2a; // arbitrary
  logic        core_clk = 1'b0;
  logic        rstn     = 1'b0;
  logic [7:0]  lsmp     = 8'h19;
  logic [10:0] rsmp     = 11'h0c8;
  logic        host_scl;
  logic        host_sda;
  int          n_mismatch = 0;
  int          n_checks   = 0;
  wire         scl_o, scl_oe, sda_o, sda_oe, en, rem;
  wire         alert_o, alert_oe, ot_o, ot_oe;
  wire         scl = host_scl & ~scl_oe;
  wire         sda = host_sda & ~sda_oe;
  always #4 core_clk = ~core_clk;
  dtlm_monitor #(
    .P_SLAVE_ADDR(ADDR), .P_CONV_CYCLES(CONV), .P_TIMEOUT_CYCLES(TMO)
  ) u_dtlm_monitor (
    .i_core_clk(core_clk), .i_rstn(rstn), .i_scl(scl), .o_scl(scl_o),
    .o_scl_oe(scl_oe), .i_sda(sda), .o_sda(sda_o), .o_sda_oe(sda_oe),
    .i_local_sample(lsmp), .i_remote_sample(rsmp),
    .o_sensor_enable(en), .o_sensor_remote(rem), .o_alert_n(alert_o),
    .o_alert_n_oe(alert_oe), .o_overtemp_output_n(ot_o),
    .o_overtemp_output_n_oe(ot_oe)
  );
  dtlm_host_model #(.P_ADDR(ADDR)) u_dtlm_host_model (
    .o_scl(host_scl), .o_sda(host_sda), .i_sda(sda)
  );
  task automatic check(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic ok;
    @(posedge core_clk);
    #1;
    u_dtlm_host_model.read_reg(p, d, ok);
    check(ok, 1'b1);
  endtask
  task automatic rd_check(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] d;
    rd(p, d);
    check(d, e);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic ok;
    @(posedge core_clk);
    #1;
    u_dtlm_host_model.write_reg(p, d, ok);
    check(ok, 1'b1);
  endtask
  task automatic wait_rem(input logic v, inout int n);
    while (rem !== v && n < 2000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask
  // two remote ends: one whole conversion saw the new samples
  task automatic step(input logic [7:0] l, input logic [10:0] r,
                      input logic ot);
    int n;
    @(posedge core_clk);
    #1;
    lsmp = l;
    rsmp = r;
    repeat (2) begin
      n = 0;
      wait_rem(1'b1, n);
      wait_rem(1'b0, n);
    end
    repeat (4) @(posedge core_clk);
    #1;
    check(ot_oe, ot);
  endtask
  task automatic period(output int p);
    int n;
    n = 0;
    p = 0;
    wait_rem(1'b0, n);
    wait_rem(1'b1, n);
    wait_rem(1'b0, p);
    wait_rem(1'b1, p);
  endtask
  task automatic t_defaults();
    logic [15:0] tbl [12] = '{16'h0546, 16'h0600, 16'h0746, 16'h1300,
      16'h0800, 16'h1400, 16'h1955, 16'h2055, 16'h210a, 16'h0400,
      16'h0300, 16'h3000};
    foreach (tbl[i]) rd_check(tbl[i][15:8], tbl[i][7:0]);
    $display("t_defaults done");
  endtask
  task automatic t_readings();
    wr(8'h11, 8'h02);
    wr(8'h12, 8'h3f);
    wr(8'h00, 8'hff);
    step(8'h19, 11'h0c8, 1'b0);
    rd_check(8'h00, 8'h19);
    rd_check(8'h01, 8'h1b);
    rd_check(8'h10, 8'h20);
    $display("t_readings done");
  endtask
  task automatic t_limits();
    step(8'h50, 11'h0c8, 1'b0);
    check(alert_oe, 1'b1);
    check({alert_o, ot_o, scl_o}, 16'h0000);
    rd_check(8'h02, 8'hc0);
    wr(8'h03, 8'h80);
    check(alert_oe, 1'b0);
    wr(8'h03, 8'h00);
    step(8'h60, 11'h0c8, 1'b1);
    rd_check(8'h02, 8'hc1);
    step(8'h50, 11'h0c8, 1'b1);
    step(8'h4a, 11'h0c8, 1'b0);
    wr(8'h21, 8'h14);
    step(8'h4a, 11'h2bf, 1'b1);
    step(8'h4a, 11'h21f, 1'b1);
    step(8'h4a, 11'h1cf, 1'b0);
    $display("t_limits done");
  endtask
  task automatic t_shutdown();
    logic [7:0] d;
    wr(8'h03, 8'h40);
    check(en, 1'b0);
    rd(8'h02, d);
    check(d[7], 1'b0);
    rd_check(8'h03, 8'h40);
    wr(8'h03, 8'h00);
    check(en, 1'b1);
    $display("t_shutdown done");
  endtask
  task automatic t_rate();
    int p;
    wr(8'h04, 8'h01);
    period(p);
    check(p[15:0], 16'(2 * CONV));
    rd_check(8'h04, 8'h01);
    wr(8'h04, 8'h00);
    period(p);
    check(p[15:0], 16'(CONV));
    $display("t_rate done");
  endtask
  task automatic t_timeout();
    logic ok;
    @(posedge core_clk);
    #1;
    u_dtlm_host_model.start();
    u_dtlm_host_model.tx_byte({ADDR, 1'b0}, 1'b1, ok);
    #60;
    check(sda_oe, 1'b1);
    repeat (TMO + 50) @(posedge core_clk);
    #1;
    check(sda_oe, 1'b0);
    u_dtlm_host_model.stop();
    rd_check(8'h21, 8'h14);
    $display("t_timeout done");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #600us;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    t_defaults();
    t_readings();
    t_limits();
    t_shutdown();
    t_rate();
    t_timeout();
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
